/* cc2_pkg.sv */
// package: register map, field layout and reset values for the channel 2 register bank
package cc2_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CAL_W  = 24;

  localparam logic [5:0] ADDR_CFG        = 6'h13;
  localparam logic [5:0] ADDR_OCAL_HIGH  = 6'h14;
  localparam logic [5:0] ADDR_OCAL_LOW   = 6'h15;
  localparam logic [5:0] ADDR_GCAL_HIGH  = 6'h16;
  localparam logic [5:0] ADDR_GCAL_LOW   = 6'h17;
  localparam logic [5:0] ADDR_CHECKSUM   = 6'h3E;
  localparam logic [5:0] ADDR_RSVD_TOP   = 6'h3F;

  localparam int unsigned CFG_PHASE_LSB  = 6;
  localparam int unsigned CFG_BYPASS_BIT = 2;
  localparam logic [15:0] CFG_WMASK      = 16'hFFC7;
  localparam logic [15:0] CAL_LOW_WMASK  = 16'hFF00;

  localparam logic [15:0] RST_CFG        = 16'h0000;
  localparam logic [15:0] RST_OCAL_HIGH  = 16'h0000;
  localparam logic [15:0] RST_OCAL_LOW   = 16'h0000;
  localparam logic [15:0] RST_GCAL_HIGH  = 16'h8000;
  localparam logic [15:0] RST_GCAL_LOW   = 16'h0000;
  localparam logic [15:0] RST_CHECKSUM   = 16'h0000;
  localparam logic [15:0] RST_RSVD_TOP   = 16'h0000;

  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_SEED       = 16'hFFFF;
  localparam int unsigned CRC_WORDS      = 5;

  typedef enum logic [1:0] {
    CC2_IN_PINS  = 2'b00,
    CC2_IN_SHORT = 2'b01,
    CC2_IN_POS   = 2'b10,
    CC2_IN_NEG   = 2'b11
  } cc2_input_sel_e;

  typedef struct packed {
    logic        wr_en;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } cc2_reg_req_s;

  typedef struct packed {
    logic signed [9:0] ch2_phase_delay;
    logic              ch2_dc_filter_bypass;
    cc2_input_sel_e    ch2_input_select;
  } cc2_cfg_s;

  typedef struct packed {
    logic [15:0] ch2_input_config;
    logic [15:0] ch2_offset_cal_high;
    logic [15:0] ch2_offset_cal_low;
    logic [15:0] ch2_gain_cal_high;
    logic [15:0] ch2_gain_cal_low;
    logic [15:0] reserved_top_word;
    logic [15:0] register_map_checksum;
  } cc2_regs_s;

endpackage : cc2_pkg

/* cc2_checksum.sv */
// crc-16 over the configuration words, one word folded per clock, restarting on change
`timescale 1ns/100ps
module cc2_checksum
  import cc2_pkg::*;
#(
  parameter int unsigned WORDS = cc2_pkg::CRC_WORDS
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    srst_in,
  input  wire logic [WORDS*16-1:0]     words_in,
  output logic      [15:0]             crc_out,
  output logic                         busy_out
);

  typedef struct packed {
    logic [WORDS*16-1:0] snap;
    logic [15:0]         acc;
    logic [15:0]         result;
    logic [3:0]          idx;
    logic                busy;
  } cc2_crc_st_s;

  cc2_crc_st_s st_q;
  cc2_crc_st_s st_d;

  function automatic logic [15:0] cc2_fold(input logic [15:0] crc, input logic [15:0] w);
    logic [15:0] c;
    c = crc;
    for (int b = 15; b >= 0; b--) begin
      c = (c[15] ^ w[b]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : cc2_fold

  always_comb begin
    st_d = st_q;
    if (words_in != st_q.snap) begin
      // any change restarts the walk so the result never mixes old and new words
      st_d.snap = words_in;
      st_d.acc  = CRC_SEED;
      st_d.idx  = 4'h0;
      st_d.busy = 1'b1;
    end else if (st_q.busy) begin
      st_d.acc = cc2_fold(st_q.acc, st_q.snap[st_q.idx*16 +: 16]);
      if (st_q.idx == 4'(WORDS - 1)) begin
        st_d.busy   = 1'b0;
        st_d.result = st_d.acc;
      end else begin
        st_d.idx = st_q.idx + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_q.snap   <= '0;
      st_q.acc    <= CRC_SEED;
      st_q.result <= RST_CHECKSUM;
      st_q.idx    <= 4'h0;
      st_q.busy   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign crc_out  = st_q.result;
  assign busy_out = st_q.busy;

endmodule : cc2_checksum

/* cc2_calibrate.sv */
// offset subtract then gain multiply on one conversion result, one registered stage
`timescale 1ns/100ps
module cc2_calibrate
  import cc2_pkg::*;
#(
  parameter int unsigned W = cc2_pkg::CAL_W
) (
  input  wire logic                core_clk_in,
  input  wire logic                srst_in,
  input  wire logic                valid_in,
  input  wire logic signed [W-1:0] sample_in,
  input  wire logic signed [W-1:0] offset_in,
  input  wire logic        [W-1:0] gain_in,
  output logic                     valid_out,
  output logic signed [W-1:0]      sample_out
);

  typedef struct packed {
    logic                valid;
    logic signed [W-1:0] sample;
  } cc2_cal_st_s;

  cc2_cal_st_s st_q;
  cc2_cal_st_s st_d;

  logic signed [W:0]       diff;
  logic signed [2*W+1:0]   prod;
  logic signed [W+2:0]     scaled;

  always_comb begin
    st_d   = st_q;
    diff   = (W+1)'(sample_in) - (W+1)'(offset_in);
    // gain is unsigned with unity at 2^(W-1), so drop W-1 fraction bits
    prod   = (2*W+2)'(diff) * (2*W+2)'($signed({1'b0, gain_in}));
    scaled = (W+3)'(prod >>> (W - 1));
    st_d.valid = valid_in;
    if (valid_in) begin
      // saturate rather than wrap; a wrapped result flips sign on overload
      if (scaled > (W+3)'(2**(W-1) - 1)) begin
        st_d.sample = {1'b0, {(W-1){1'b1}}};
      end else if (scaled < -(W+3)'(2**(W-1))) begin
        st_d.sample = {1'b1, {(W-1){1'b0}}};
      end else begin
        st_d.sample = scaled[W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign valid_out  = st_q.valid;
  assign sample_out = st_q.sample;

endmodule : cc2_calibrate

/* cc2_regs.sv */
// channel 2 configuration and calibration register bank with checksum and top word
// Notes on behaviour
// - upper ten config bits: signed phase delay
// - config bits five to three read zero
// - config bit two bypasses dc filter
// - two-bit selector picks pins, short, test signals
// - 24-bit offset split high word, low byte
// - bits seven to zero of the calibration low registers read zero, ignore writes
// - gain high word resets to 8000h
// - gain low byte in next register, read/write
// - calibration registers at consecutive addresses
// - read-only checksum word, reset zero
// - top word reserved read/write, no effect
`timescale 1ns/100ps
module cc2_regs
  import cc2_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     srst_in,
  input  wire cc2_pkg::cc2_reg_req_s    req_in,
  output logic [15:0]                   rdata_out,
  output cc2_pkg::cc2_cfg_s             cfg_out,
  input  wire logic                     sample_valid_in,
  input  wire logic signed [23:0]       sample_in,
  output logic                          sample_valid_out,
  output logic signed [23:0]            sample_out,
  output logic                          checksum_busy_out
);

  import cc2_pkg::*;

  typedef struct packed {
    cc2_regs_s   regs;
    logic [15:0] rdata;
  } cc2_bank_st_s;

  cc2_bank_st_s st_q;
  cc2_bank_st_s st_d;
  logic [15:0]  crc;
  logic [15:0]  sel_word;

  always_comb begin
    st_d = st_q;
    st_d.regs.register_map_checksum = crc;
    if (req_in.wr_en) begin
      case (req_in.addr)
        ADDR_CFG: begin
          st_d.regs.ch2_input_config = req_in.wdata & CFG_WMASK;
        end
        ADDR_OCAL_HIGH: begin
          st_d.regs.ch2_offset_cal_high = req_in.wdata;
        end
        ADDR_OCAL_LOW: begin
          st_d.regs.ch2_offset_cal_low = req_in.wdata & CAL_LOW_WMASK;
        end
        ADDR_GCAL_HIGH: begin
          st_d.regs.ch2_gain_cal_high = req_in.wdata;
        end
        ADDR_GCAL_LOW: begin
          st_d.regs.ch2_gain_cal_low = req_in.wdata & CAL_LOW_WMASK;
        end
        ADDR_RSVD_TOP: begin
          st_d.regs.reserved_top_word = req_in.wdata;
        end
        default: begin
          // checksum and unmapped addresses ignore writes
        end
      endcase
    end
  end

  // read data comes from flip-flops, one cycle after the address is presented
  always_comb begin
    case (req_in.addr)
      ADDR_CFG:       sel_word = st_q.regs.ch2_input_config & CFG_WMASK;
      ADDR_OCAL_HIGH: sel_word = st_q.regs.ch2_offset_cal_high;
      ADDR_OCAL_LOW:  sel_word = st_q.regs.ch2_offset_cal_low & CAL_LOW_WMASK;
      ADDR_GCAL_HIGH: sel_word = st_q.regs.ch2_gain_cal_high;
      ADDR_GCAL_LOW:  sel_word = st_q.regs.ch2_gain_cal_low & CAL_LOW_WMASK;
      ADDR_CHECKSUM:  sel_word = st_q.regs.register_map_checksum;
      ADDR_RSVD_TOP:  sel_word = st_q.regs.reserved_top_word;
      default:        sel_word = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_q.regs.ch2_input_config      <= RST_CFG;
      st_q.regs.ch2_offset_cal_high   <= RST_OCAL_HIGH;
      st_q.regs.ch2_offset_cal_low    <= RST_OCAL_LOW;
      st_q.regs.ch2_gain_cal_high     <= RST_GCAL_HIGH;
      st_q.regs.ch2_gain_cal_low      <= RST_GCAL_LOW;
      st_q.regs.reserved_top_word     <= RST_RSVD_TOP;
      st_q.regs.register_map_checksum <= RST_CHECKSUM;
      st_q.rdata                      <= 16'h0000;
    end else begin
      st_q.regs  <= st_d.regs;
      st_q.rdata <= sel_word;
    end
  end

  // the reserved top word is kept out of the checksum and drives nothing
  cc2_checksum #(
    .WORDS (CRC_WORDS)
  ) u_checksum (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .words_in    ({st_q.regs.ch2_gain_cal_low, st_q.regs.ch2_gain_cal_high,
                   st_q.regs.ch2_offset_cal_low, st_q.regs.ch2_offset_cal_high,
                   st_q.regs.ch2_input_config}),
    .crc_out     (crc),
    .busy_out    (checksum_busy_out)
  );

  cc2_calibrate #(
    .W (CAL_W)
  ) u_calibrate (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .valid_in    (sample_valid_in),
    .sample_in   (sample_in),
    .offset_in   ({st_q.regs.ch2_offset_cal_high, st_q.regs.ch2_offset_cal_low[15:8]}),
    .gain_in     ({st_q.regs.ch2_gain_cal_high, st_q.regs.ch2_gain_cal_low[15:8]}),
    .valid_out   (sample_valid_out),
    .sample_out  (sample_out)
  );

  assign rdata_out = st_q.rdata;
  assign cfg_out.ch2_phase_delay      = st_q.regs.ch2_input_config[15:CFG_PHASE_LSB];
  assign cfg_out.ch2_dc_filter_bypass = st_q.regs.ch2_input_config[CFG_BYPASS_BIT];
  assign cfg_out.ch2_input_select     = cc2_input_sel_e'(st_q.regs.ch2_input_config[1:0]);

endmodule : cc2_regs

/* cc2_regs_assertions.sv */
// checker for the channel 2 register bank ports
`timescale 1ns/100ps
module cc2_regs_assertions
  import cc2_pkg::*;
(
  input wire logic                  core_clk_in,
  input wire logic                  srst_in,
  input wire cc2_pkg::cc2_reg_req_s req_in,
  input wire logic [15:0]           rdata_out,
  input wire cc2_pkg::cc2_cfg_s     cfg_out,
  input wire logic                  sample_valid_in,
  input wire logic                  sample_valid_out,
  input wire logic                  checksum_busy_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);
  logic wcfg;
  assign wcfg = req_in.wr_en && req_in.addr == 6'h13;
  property p_rsv; req_in.addr == 6'h13 |=> rdata_out[5:3] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("cfg reserved bits set");
  property p_low; req_in.addr inside {6'h15, 6'h17} |=> rdata_out[7:0] == 8'h00; endproperty
  a_low: assert property (p_low) else $error("cal low byte set");
  property p_ph; wcfg |=> cfg_out.ch2_phase_delay == $past(req_in.wdata[15:6]); endproperty
  a_ph: assert property (p_ph) else $error("phase not written");
  property p_sel; wcfg |=> {cfg_out.ch2_dc_filter_bypass, cfg_out.ch2_input_select}
    == $past(req_in.wdata[2:0]); endproperty
  a_sel: assert property (p_sel) else $error("bypass or select wrong");
  property p_hold; !wcfg |=> $stable(cfg_out); endproperty
  a_hold: assert property (p_hold) else $error("cfg moved without write");
  property p_vld; sample_valid_in |=> sample_valid_out; endproperty
  a_vld: assert property (p_vld) else $error("sample valid lost");
  property p_busy; $rose(checksum_busy_out) |-> ##[1:8] !checksum_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("checksum stuck busy");
  property p_grst; disable iff (1'b0) srst_in ##1 (!srst_in && req_in.addr == 6'h16
    && !req_in.wr_en) |=> rdata_out == 16'h8000; endproperty
  a_grst: assert property (p_grst) else $error("gain high reset wrong");
  c_wcfg: cover property (wcfg);
  c_vld: cover property (sample_valid_out);
  c_busy: cover property ($fell(checksum_busy_out));
endmodule : cc2_regs_assertions
bind cc2_regs cc2_regs_assertions cc2_regs_assertions_inst (.core_clk_in(core_clk_in),
  .srst_in(srst_in), .req_in(req_in), .rdata_out(rdata_out), .cfg_out(cfg_out),
  .sample_valid_in(sample_valid_in), .sample_valid_out(sample_valid_out),
  .checksum_busy_out(checksum_busy_out));

/* channel2_config_calibration_regs_tb_top.sv */
// testbench for the channel 2 register bank
`timescale 1ns/100ps
module channel2_config_calibration_regs_tb_top;
  import cc2_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  cc2_reg_req_s       req = '0;
  logic [15:0]        rdata;
  cc2_cfg_s           cfg;
  logic               vin = 1'b0;
  logic signed [23:0] sin = '0;
  logic               vout;
  logic signed [23:0] sout;
  logic               busy;
  logic [15:0]        sh [64];
  logic [15:0]        wm [64];
  logic [31:0]        rng = 32'h0000_005f;
  int                 bad_count = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  always #20 clk = ~clk;
  cc2_regs cc2_regs_inst (.core_clk_in(clk), .srst_in(rst), .req_in(req), .rdata_out(rdata),
    .cfg_out(cfg), .sample_valid_in(vin), .sample_in(sin), .sample_valid_out(vout),
    .sample_out(sout), .checksum_busy_out(busy));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // crc over the shadow words 13h..17h, msb first
  function automatic logic [15:0] crc();
    logic [15:0] c;
    c = 16'hffff;
    for (int w = 19; w < 24; w++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ sh[w][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction : crc
  function automatic logic [23:0] cal(input logic signed [23:0] s);
    longint d;
    d = longint'(s) - longint'($signed({sh[20], sh[21][15:8]}));
    d = (d * longint'({sh[22], sh[23][15:8]})) >>> 23;
    if (d > 64'sh7f_ffff) d = 64'sh7f_ffff;
    if (d < -64'sh80_0000) d = -64'sh80_0000;
    return d[23:0];
  endfunction : cal
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    req <= '{1'b1, a, d};
    if (wm[a] != 16'h0000) sh[a] = d & wm[a];
    @(negedge clk);
    req.wr_en <= 1'b0;
  endtask : wr
  // waits out a checksum recompute so 3Eh can be compared
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    // the 3eh register copies the result one edge after busy falls
    @(negedge clk);
    req.addr <= a;
    @(negedge clk);
    check(rdata, (a == 6'h3e) ? crc() : sh[a]);
  endtask : rd
  task automatic do_reset(input int n);
    rst <= 1'b1;
    repeat (n) @(negedge clk);
    foreach (sh[i]) sh[i] = 16'h0000;
    sh[6'h16] = 16'h8000;
    rst <= 1'b0;
    req.addr <= 6'h16;
    @(negedge clk);
    check(rdata, 16'h8000);
    req.addr <= 6'h3e;
    @(negedge clk);
    check(rdata, 16'h0000);
  endtask : do_reset
  task automatic smp(input logic signed [23:0] s);
    vin <= 1'b1;
    sin <= s;
    @(negedge clk);
    check(vout, 1'b1);
    check(sout, cal(s));
  endtask : smp
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    logic [5:0] al [8];
    al = '{6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h3e, 6'h3f, 6'h2a};
    foreach (wm[i]) wm[i] = 16'h0000;
    wm[6'h13] = 16'hffc7;
    wm[6'h14] = 16'hffff;
    wm[6'h15] = 16'hff00;
    wm[6'h16] = 16'hffff;
    wm[6'h17] = 16'hff00;
    wm[6'h3f] = 16'hffff;
    do_reset(10);
    foreach (al[i]) rd(al[i]);
    for (int s = 0; s < 4; s++) begin
      wr(6'h13, 16'hfff8 | 16'(s * 3));
      check(cfg, {sh[19][15:6], sh[19][2:0]});
      @(negedge clk);
      check(busy, 1'b1);
      rd(6'h13);
    end
    // default calibration is unity, so the extremes must pass unchanged
    smp(24'h7f_ffff);
    smp(24'h80_0000);
    for (int i = 0; i < 150; i++) begin
      rng = xs(rng);
      wr(al[rng[2:0]], rng[31:16]);
      rd(al[rng[2:0]]);
      check(cfg, {sh[19][15:6], sh[19][2:0]});
      smp(rng[23:0] ^ 24'h5a_5a5a);
      vin <= 1'b0;
    end
    @(negedge clk);
    check(vout, 1'b0);
    check(busy, 1'b0);
    rd(6'h3e);
    do_reset(2);
    give_verdict();
  end
endmodule : channel2_config_calibration_regs_tb_top
